// ===== hdl/frt_axil_slave.sv
// axi4-lite slave that turns bus beats into register strobes
`timescale 1ns/10ps
`default_nettype none
`include "frt_consts.svh"
module frt_axil_slave import frt_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic wr_en_o,
	output logic [ADDR_W-1:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_err_i,
	output logic rd_en_o,
	output logic [ADDR_W-1:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_err_i
);
	// ==========================================================
	// elaboration check
	if (ADDR_W < 6) begin : g_bad_addr
		$error("frt_axil_slave: ADDR_W too small for the map");
	end

	logic aw_full_q; // write address held
	logic w_full_q; // write data held
	logic [ADDR_W-1:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// write fires once address and data are both held and no write response is pending
	assign wr_en_o = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_addr_o = aw_q;
	assign wr_data_o = wd_q;
	assign wr_strb_o = ws_q;
	// read fires on the address handshake
	assign rd_en_o = arvalid_i & arready_q;
	assign rd_addr_o = araddr_i;

	// ==========================================================
	// write channels, address and data taken in either order
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= `FRT_RESP_OKAY;
		end else begin
			if (awvalid_i && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_q <= awaddr_i;
			end
			if (wvalid_i && !w_full_q) begin
				w_full_q <= 1'b1;
				wd_q <= wdata_i;
				ws_q <= wstrb_i;
			end
			if (wr_en_o) begin
				// response follows both halves
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_err_i ? `FRT_RESP_SLVERR : `FRT_RESP_OKAY;
			end else if (bvalid_q && bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read channel, data captured on the address handshake
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `FRT_RESP_OKAY;
		end else if (rd_en_o) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data_i;
			rresp_q <= rd_err_i ? `FRT_RESP_SLVERR : `FRT_RESP_OKAY;
		end else if (rvalid_q && rready_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	assign awready_o = ~aw_full_q;
	assign wready_o = ~w_full_q;
	assign bvalid_o = bvalid_q;
	assign bresp_o = bresp_q;
	assign arready_o = arready_q;
	assign rvalid_o = rvalid_q;
	assign rdata_o = rdata_q;
	assign rresp_o = rresp_q;
endmodule
`default_nettype wire

// ===== hdl/frt_consts.svh
// constants of the free running timer: offsets, fields, reset values
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH
// ==========================================================
// register byte offsets, one aligned 32-bit word each
`define FRT_OFF_CNT_HI 8'h00
`define FRT_OFF_CNT_LO 8'h04
`define FRT_OFF_SHD_HI 8'h08
`define FRT_OFF_SHD_LO 8'h0c
`define FRT_OFF_STATUS 8'h10
`define FRT_OFF_CTL1 8'h14
`define FRT_OFF_CTL2 8'h18
`define FRT_OFF_EVT_STS 8'h1c
`define FRT_OFF_EVT_MASK 8'h20
// ==========================================================
// field positions
`define FRT_BIT_OVF_FLAG 5
`define FRT_BIT_OVF_IE 5
`define FRT_BIT_GMASK 7
`define FRT_BIT_EVT_OVF 0
// ==========================================================
// reset and reload value, and the last count before rollover
`define FRT_CNT_RESET 16'hfffc
`define FRT_CNT_MAX 16'hffff
// ==========================================================
// prescale select codes
`define FRT_PSEL_DIV4 2'h0
`define FRT_PSEL_DIV2 2'h1
`define FRT_PSEL_DIV8 2'h2
`define FRT_PSEL_EXT 2'h3
// ==========================================================
// bus response codes
`define FRT_RESP_OKAY 2'h0
`define FRT_RESP_SLVERR 2'h2
`endif

// ===== hdl/frt_pkg.sv
// types shared by the free running timer files
`default_nettype none
`include "frt_consts.svh"
package frt_pkg;
	// prescale selection
	typedef enum logic [1:0] {
		frt_div4 = `FRT_PSEL_DIV4,
		frt_div2 = `FRT_PSEL_DIV2,
		frt_div8 = `FRT_PSEL_DIV8,
		frt_ext = `FRT_PSEL_EXT
	} frt_psel_e;
	// one count value
	typedef logic [15:0] frt_cnt_t;
	// one register byte
	typedef logic [7:0] frt_byte_t;
endpackage
`default_nettype wire

// ===== hdl/frt_tick_gen.sv
// timer tick generator: cpu clock prescaler and external clock edges
`timescale 1ns/10ps
`default_nettype none
`include "frt_consts.svh"
module frt_tick_gen import frt_pkg::*; #(
	parameter int DIV_W = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] psel_i,
	input wire logic stop_i,
	input wire logic ext_clk_i,
	output logic tick_o
);
	// ==========================================================
	// elaboration check
	if (DIV_W < 3) begin : g_bad_div
		$error("frt_tick_gen: DIV_W must cover divide by 8");
	end

	logic [DIV_W-1:0] div_q; // free prescale counter
	logic ext_s1_q; // first synchroniser stage
	logic ext_s2_q; // second synchroniser stage
	logic ext_s3_q; // previous synchronised level
	logic tick_d; // selected tick
	logic tick_q;

	// ==========================================================
	// prescaler, frozen in deep stop so the phase resumes
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= '0;
		end else if (!stop_i) begin
			div_q <= div_q + 1'b1;
		end
	end

	// external pin synchroniser and edge memory
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_clk_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// tick selection by prescale code
	always_comb begin
		unique case (frt_psel_e'(psel_i))
			frt_div2: tick_d = div_q[0];
			frt_div4: tick_d = &div_q[1:0];
			frt_div8: tick_d = &div_q[2:0];
			frt_ext: tick_d = ext_s2_q & ~ext_s3_q;
		endcase
	end

	// registered one-cycle tick
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_d & ~stop_i;
		end
	end
	assign tick_o = tick_q;

	// divide by two never ticks twice in a row
	a_div2_spacing: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(tick_q && psel_i == `FRT_PSEL_DIV2 && $stable(psel_i))
		|=> !tick_q
	) else $error("divide by two ticked on consecutive cycles");
endmodule
`default_nettype wire

// ===== hdl/frt_timer_top.sv
// free running 16-bit timer with byte-wide count registers
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "frt_consts.svh"
module frt_timer_top import frt_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic deep_stop_i,
	input wire logic ext_clk_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic irq_o
);
	// ==========================================================
	// elaboration check
	if (ADDR_W < 6) begin : g_bad_addr
		$error("frt_timer_top: ADDR_W too small for the map");
	end

	// bus strobes from the slave
	logic wr_en; // one-cycle write strobe
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en; // one-cycle read strobe
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;

	// timer state
	frt_cnt_t cnt_q; // free running count
	logic tick; // selected timer tick
	logic adv; // count advances this cycle
	logic reload; // count goes back to the reset value
	logic ovf_set; // rollover this cycle
	logic ovf_clr; // second clear step this cycle
	logic ovf_flag_q; // overflow flag
	logic ovf_arm_q; // first clear step done
	frt_byte_t lo_hold_q; // captured low byte
	logic lo_held_q; // a high read is waiting for its low read
	logic ovf_irq_en_q; // overflow interrupt enable
	logic gmask_q; // interrupt mask of the overflow flag path; the event path ignores it
	logic [1:0] psel_q; // prescale select
	logic evt_sts_q; // sticky overflow event
	logic evt_mask_q; // event mask
	logic irq_q;

	// decoded accesses
	logic rd_hi_m, rd_lo_m, rd_hi_s, rd_lo_s, rd_sts, rd_evt;
	logic wr_lo_m, wr_lo_s, wr_ctl1, wr_ctl2, wr_mask;

	// ==========================================================
	// bus slave and tick source
	frt_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.araddr_i(s_axi_araddr_i),
		.arvalid_i(s_axi_arvalid_i),
		.arready_o(s_axi_arready_o),
		.rdata_o(s_axi_rdata_o),
		.rresp_o(s_axi_rresp_o),
		.rvalid_o(s_axi_rvalid_o),
		.rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_err_i(wr_err),
		.rd_en_o(rd_en),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_err_i(rd_err)
	);

	frt_tick_gen #(.DIV_W(3)) u_tick (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.psel_i(psel_q),
		.stop_i(deep_stop_i),
		.ext_clk_i(ext_clk_i),
		.tick_o(tick)
	);

	// ==========================================================
	// address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	assign rd_hi_m = rd_en & hit(rd_addr, `FRT_OFF_CNT_HI);
	assign rd_lo_m = rd_en & hit(rd_addr, `FRT_OFF_CNT_LO);
	assign rd_hi_s = rd_en & hit(rd_addr, `FRT_OFF_SHD_HI);
	assign rd_lo_s = rd_en & hit(rd_addr, `FRT_OFF_SHD_LO);
	assign rd_sts = rd_en & hit(rd_addr, `FRT_OFF_STATUS);
	assign rd_evt = rd_en & hit(rd_addr, `FRT_OFF_EVT_STS);
	assign wr_lo_m = wr_en & hit(wr_addr, `FRT_OFF_CNT_LO);
	assign wr_lo_s = wr_en & hit(wr_addr, `FRT_OFF_SHD_LO);
	assign wr_ctl1 = wr_en & wr_strb[0] & hit(wr_addr, `FRT_OFF_CTL1);
	assign wr_ctl2 = wr_en & wr_strb[0] & hit(wr_addr, `FRT_OFF_CTL2);
	assign wr_mask = wr_en & wr_strb[0] & hit(wr_addr, `FRT_OFF_EVT_MASK);

	// ==========================================================
	// counter; light sleep has no input here so it cannot disturb it
	assign adv = tick & ~deep_stop_i;
	assign reload = wr_lo_m | wr_lo_s;
	assign ovf_set = adv & ~reload & (cnt_q == `FRT_CNT_MAX);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= `FRT_CNT_RESET;
		end else if (reload) begin
			cnt_q <= `FRT_CNT_RESET;
		end else if (adv) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// ==========================================================
	// overflow flag and its two-step clear
	assign ovf_clr = ovf_arm_q & (rd_lo_m | wr_lo_m);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf_flag_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_flag_q <= 1'b1;
		end else if (ovf_clr) begin
			ovf_flag_q <= 1'b0;
		end
	end

	// first step only counts when the flag was seen set
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf_arm_q <= 1'b0;
		end else if (rd_sts && ovf_flag_q) begin
			ovf_arm_q <= 1'b1;
		end else if (rd_lo_m || wr_lo_m) begin
			ovf_arm_q <= 1'b0;
		end
	end

	// ==========================================================
	// low byte capture for paired reads; shared by both views
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lo_hold_q <= '0;
			lo_held_q <= 1'b0;
		end else if ((rd_hi_m || rd_hi_s) && !lo_held_q) begin
			lo_hold_q <= cnt_q[7:0];
			lo_held_q <= 1'b1;
		end else if (rd_lo_m || rd_lo_s) begin
			lo_held_q <= 1'b0;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf_irq_en_q <= 1'b0;
		end else if (wr_ctl1) begin
			ovf_irq_en_q <= wr_data[`FRT_BIT_OVF_IE];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			psel_q <= `FRT_PSEL_DIV4;
			gmask_q <= 1'b0;
		end else if (wr_ctl2) begin
			psel_q <= wr_data[1:0];
			gmask_q <= wr_data[`FRT_BIT_GMASK];
		end
	end

	// ==========================================================
	// sticky event, read clears, a new event wins over the clear
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			evt_sts_q <= 1'b0;
		end else begin
			evt_sts_q <= ovf_set | (evt_sts_q & ~rd_evt);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			evt_mask_q <= 1'b0;
		end else if (wr_mask) begin
			evt_mask_q <= wr_data[`FRT_BIT_EVT_OVF];
		end
	end

	// level interrupt; a masked flag stays pending until unmasked
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ovf_flag_q & ovf_irq_en_q & ~gmask_q)
				| (evt_sts_q & evt_mask_q);
		end
	end
	assign irq_o = irq_q;

	// ==========================================================
	// read data and error answers
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (hit(rd_addr, `FRT_OFF_CNT_HI)
				|| hit(rd_addr, `FRT_OFF_SHD_HI)) begin
			rd_data[7:0] = cnt_q[15:8];
		end else if (hit(rd_addr, `FRT_OFF_CNT_LO)
				|| hit(rd_addr, `FRT_OFF_SHD_LO)) begin
			rd_data[7:0] = lo_held_q ? lo_hold_q : cnt_q[7:0];
		end else if (hit(rd_addr, `FRT_OFF_STATUS)) begin
			rd_data[`FRT_BIT_OVF_FLAG] = ovf_flag_q;
		end else if (hit(rd_addr, `FRT_OFF_CTL1)) begin
			rd_data[`FRT_BIT_OVF_IE] = ovf_irq_en_q;
		end else if (hit(rd_addr, `FRT_OFF_CTL2)) begin
			rd_data[1:0] = psel_q;
			rd_data[`FRT_BIT_GMASK] = gmask_q;
		end else if (hit(rd_addr, `FRT_OFF_EVT_STS)) begin
			rd_data[`FRT_BIT_EVT_OVF] = evt_sts_q;
		end else if (hit(rd_addr, `FRT_OFF_EVT_MASK)) begin
			rd_data[`FRT_BIT_EVT_OVF] = evt_mask_q;
		end else begin
			rd_err = 1'b1; // unmapped
		end
	end

	// writes outside the map answer with an error
	assign wr_err = ~(hit(wr_addr, `FRT_OFF_CNT_HI)
		| hit(wr_addr, `FRT_OFF_CNT_LO) | hit(wr_addr, `FRT_OFF_SHD_HI)
		| hit(wr_addr, `FRT_OFF_SHD_LO) | hit(wr_addr, `FRT_OFF_STATUS)
		| hit(wr_addr, `FRT_OFF_CTL1) | hit(wr_addr, `FRT_OFF_CTL2)
		| hit(wr_addr, `FRT_OFF_EVT_STS) | hit(wr_addr, `FRT_OFF_EVT_MASK));

	// ==========================================================
	// checks
	a_low_write_reload: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		reload |=> cnt_q == `FRT_CNT_RESET
	) else $error("low byte write did not reload the count");

	a_count_step: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(adv && !reload) |=> cnt_q == $past(cnt_q) + 16'h0001
	) else $error("count did not advance by one on a tick");

	a_stop_freeze: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(deep_stop_i && !reload) |=> $stable(cnt_q)
	) else $error("count moved in deep stop");

	a_rollover_flag: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(adv && !reload && cnt_q == `FRT_CNT_MAX)
		|=> ovf_flag_q && cnt_q == 16'h0000
	) else $error("rollover did not set the overflow flag");

	a_flag_clear_cause: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		$fell(ovf_flag_q) |-> $past(ovf_arm_q) && $past(rd_lo_m || wr_lo_m)
	) else $error("overflow flag cleared without the two steps");

	a_shadow_keeps_flag: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(ovf_flag_q && (rd_lo_s || rd_hi_s)) |=> ovf_flag_q
	) else $error("shadow access cleared the overflow flag");

	a_hold_frozen: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(lo_held_q && !rd_lo_m && !rd_lo_s)
		|=> lo_held_q && $stable(lo_hold_q)
	) else $error("captured low byte changed before the low read");

	a_live_low: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		((rd_lo_m || rd_lo_s) && !lo_held_q) |-> rd_data[7:0] == cnt_q[7:0]
	) else $error("unpaired low read did not return the live byte");

	a_irq_raise: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(ovf_flag_q && ovf_irq_en_q && !gmask_q) |=> irq_q
	) else $error("enabled overflow did not raise the interrupt");
endmodule
`default_nettype wire

// ===== sim/frt_tb.sv
// self-checking bench for the free running timer block
`timescale 1ns/10ps
`default_nettype none
`include "frt_consts.svh"
module tb import frt_pkg::*; ;
	// ==========================================================
	// stimulus, response and bookkeeping
	logic clk, rst_b, stop, ext; // clock, reset, deep stop, ext pin
	logic [7:0] awaddr, araddr; // bus addresses
	logic [31:0] wdata, rdata, d; // bus data, last read word
	logic awvalid, wvalid, bready, arvalid, rready; // master side
	logic [3:0] strb; // write byte strobes
	logic awready, wready, bvalid, arready, rvalid, irq; // slave side
	logic [1:0] bresp, rresp, r; // responses, last response
	logic [1:0] codes [3] = '{`FRT_PSEL_DIV2, `FRT_PSEL_DIV4,
		`FRT_PSEL_DIV8}; // prescale codes under test
	int fails = 0, tests_run = 0, seed, cyc = 0, tstamp, t0, span, i;
	frt_cnt_t m_cnt, a, b, diff; // model count and samples
	logic ok; // rate within tolerance
	// ==========================================================
	// device under test
	frt_timer_top #(.ADDR_W(8)) uut (.core_clk_i(clk), .rst_b_i(rst_b),
		.deep_stop_i(stop), .ext_clk_i(ext), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq));
	// ==========================================================
	// clock, 40 ns period, and a free cycle counter
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// ==========================================================
	// helpers
	// compare and count; report at once on a difference
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus write; address and data released when each is taken
	task axw(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	// one bus read; word and response land in d and r
	task axr(input logic [7:0] ad);
		@(posedge clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	// read one byte register and expect an okay answer with ex
	task rchk(input logic [7:0] ad, input logic [7:0] ex);
		axr(ad);
		chk({22'h0, r, d[7:0]}, {22'h0, `FRT_RESP_OKAY, ex});
	endtask
	// 16-bit read, high byte first so both bytes match
	task rd16(input logic [7:0] hi, output frt_cnt_t v);
		tstamp = cyc;
		axr(hi);
		v[15:8] = d[7:0];
		axr(hi + 8'h04);
		v[7:0] = d[7:0];
	endtask
	// external clock pulses, each one step of the model count
	task pulse(input int n);
		repeat (n) begin
			ext <= 1'b1;
			repeat (3) @(posedge clk);
			ext <= 1'b0;
			repeat (3) @(posedge clk);
			m_cnt++;
		end
		repeat (6) @(posedge clk); // synchroniser latency
	endtask
	// interrupt level after its registered delay
	task irqchk(input logic ex);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, {31'h0, ex});
	endtask
	// verdict, the only place the run ends
	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================================
	// watchdog against a hung handshake
	initial begin
		#400000;
		fails++;
		$display("MISMATCH at %0t: timeout", $time);
		finish_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		seed = 74129;
		{rst_b, ext, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		strb = 4'hf;
		stop = 1'b1; // frozen so reset values read exactly
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		m_cnt = `FRT_CNT_RESET;
		// reset values of both views and registers
		rd16(`FRT_OFF_CNT_HI, a);
		chk(a, m_cnt);
		rd16(`FRT_OFF_SHD_HI, a);
		chk(a, m_cnt);
		rchk(`FRT_OFF_STATUS, 8'h00);
		rchk(`FRT_OFF_CTL1, 8'h00);
		// unmapped places answer with an error
		axr(8'h24);
		chk({30'h0, r}, {30'h0, `FRT_RESP_SLVERR});
		axw(8'hfc, $random(seed));
		chk({30'h0, r}, {30'h0, `FRT_RESP_SLVERR});
		// external clock counting
		axw(`FRT_OFF_CTL2, {30'h0, `FRT_PSEL_EXT});
		stop <= 1'b0;
		pulse(2);
		rd16(`FRT_OFF_CNT_HI, a);
		chk(a, m_cnt);
		// captured low byte survives a second high read
		axr(`FRT_OFF_CNT_HI);
		pulse(1);
		axr(`FRT_OFF_SHD_HI);
		rchk(`FRT_OFF_CNT_LO, 8'hfe);
		rchk(`FRT_OFF_CNT_LO, m_cnt[7:0]);
		// rollover sets the flag; interrupt waits for enable and mask
		pulse(1);
		irqchk(1'b0);
		axw(`FRT_OFF_CTL1, 32'h20);
		irqchk(1'b1);
		axw(`FRT_OFF_CTL2, 32'h83);
		irqchk(1'b0);
		axw(`FRT_OFF_CTL2, 32'h03);
		irqchk(1'b1);
		// shadow low keeps the flag, main low clears it
		rchk(`FRT_OFF_STATUS, 8'h20);
		rchk(`FRT_OFF_SHD_LO, 8'h00);
		rchk(`FRT_OFF_STATUS, 8'h20);
		rchk(`FRT_OFF_CNT_LO, 8'h00);
		rchk(`FRT_OFF_STATUS, 8'h00);
		irqchk(1'b0);
		// reload by write; clear step two needs an armed status read
		axw(`FRT_OFF_CNT_LO, $random(seed));
		m_cnt = `FRT_CNT_RESET;
		rd16(`FRT_OFF_CNT_HI, a);
		chk(a, m_cnt);
		pulse(4);
		rchk(`FRT_OFF_CNT_LO, 8'h00);
		rchk(`FRT_OFF_STATUS, 8'h20);
		axw(`FRT_OFF_CNT_LO, $random(seed));
		rchk(`FRT_OFF_STATUS, 8'h00);
		m_cnt = `FRT_CNT_RESET;
		// sticky event bit, cleared by its read, drives the line
		rchk(`FRT_OFF_EVT_STS, 8'h01);
		rchk(`FRT_OFF_EVT_STS, 8'h00);
		axw(`FRT_OFF_CTL1, 32'h00);
		axw(`FRT_OFF_EVT_MASK, 32'h01);
		pulse(4);
		irqchk(1'b1);
		rchk(`FRT_OFF_EVT_STS, 8'h01);
		irqchk(1'b0);
		// a write with byte lane zero off leaves the enable alone
		strb <= 4'h0;
		axw(`FRT_OFF_CTL1, 32'h20);
		strb <= 4'hf;
		rchk(`FRT_OFF_CTL1, 8'h00);
		// shadow low write reloads; high write loads nothing
		axw(`FRT_OFF_SHD_LO, $random(seed));
		rd16(`FRT_OFF_SHD_HI, a);
		chk(a, `FRT_CNT_RESET);
		axw(`FRT_OFF_CNT_HI, $random(seed));
		rd16(`FRT_OFF_CNT_HI, a);
		chk(a, `FRT_CNT_RESET);
		// deep stop holds the count while the clock keeps running
		axw(`FRT_OFF_CTL2, {30'h0, `FRT_PSEL_DIV2});
		stop <= 1'b1;
		rd16(`FRT_OFF_SHD_HI, a);
		repeat (40) @(posedge clk);
		rd16(`FRT_OFF_SHD_HI, b);
		chk(b, a);
		// reset while stopped restarts from the reset count
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd16(`FRT_OFF_CNT_HI, a);
		chk(a, `FRT_CNT_RESET);
		stop <= 1'b0;
		// counting rate of the three divider prescale codes over a measured span
		for (i = 0; i < 3; i++) begin
			axw(`FRT_OFF_CTL2, {30'h0, codes[i]});
			rd16(`FRT_OFF_SHD_HI, a);
			t0 = tstamp;
			repeat (96) @(posedge clk);
			rd16(`FRT_OFF_SHD_HI, b);
			span = (tstamp - t0) / (2 << i);
			diff = b - a;
			ok = (diff >= span - 1) && (diff <= span + 1);
			chk({31'h0, ok}, 32'h1);
		end
		finish_test();
	end
endmodule
`default_nettype wire
